// ### design/saps_defines.vh
`ifndef SAPS_DEFINES_VH
`define SAPS_DEFINES_VH

// register byte offsets on the apb bus
`define SAPS_OFS_CTRL 8'h00
`define SAPS_OFS_STATUS 8'h04
`define SAPS_OFS_DATA 8'h08
`define SAPS_OFS_LAST 8'h0c

// control register fields and reset values
`define SAPS_CTRL_FIXED_BIT 0
`define SAPS_CTRL_CAPTURE_BIT 1
`define SAPS_CTRL_RESET 2'h2

// status register fields
`define SAPS_STAT_ACTIVE_BIT 0
`define SAPS_STAT_STATE_LSB 1
`define SAPS_STAT_COUNT_LSB 8
`define SAPS_STAT_FULL_BIT 13

// data register fields
`define SAPS_DATA_VALID_BIT 16

// last-result register fields
`define SAPS_LAST_CFG_LSB 8
`define SAPS_LAST_COUNT_LSB 16

// configuration word layout inside a captured entry
`define SAPS_CFG_SGL_BIT 2
`define SAPS_CFG_POL_BIT 1
`define SAPS_CFG_BIT_ORDER_FLAG_BIT 0
`define SAPS_CFG_RESET 3'h5

// conversion and buffer geometry
`define SAPS_RESULT_BITS 8
`define SAPS_CFG_BITS 3
`define SAPS_FIFO_DEPTH 16
`define SAPS_MSB_INDEX 3'h7
`define SAPS_LSB_REPLAY_FIRST 3'h1

`endif

// ### design/saps_top.v
// Function
// [RULE1] device works only while select is low; high means idle and output released
// [RULE2] bits change on falling shift edges, sampled on rising shift edges
// [RULE3] multiplexed mode receives configuration first, then drives result on shared wire
// [RULE4] select falling starts a transfer; multiplexed mode then hunts for start bit
// [RULE5] after start, shift in three configuration bits, apply them, begin conversion
// [RULE6] after configuration, send one null bit, then the conversion result
// [RULE7] host raises select after each exchange; device returns to initial state
// [RULE8] fixed mode takes no configuration; first clock pulse enables output, null bit first
// [RULE9] host allows ten microseconds wake-up before the critical falling clock
// [RULE10] at shift clock of 100kHz or less wake-up needs no extra delay
// [RULE11] multiplexed mode meets wake-up with about one microsecond setup time
// [RULE12] after the full result, zeros go out while select stays low
// [RULE13] result is an eight-bit unsigned successive approximation code
// [RULE14] multiplexed mode converts either input to ground or their difference
// [RULE15] first one sampled is the start; leading zeros and later input ignored
// [RULE16] single-ended picks input by polarity flag; differential picks subtraction direction
// [RULE17] msb first then zeros, or msb first then lsb first then zeros
// [RULE18] device drives shared wire low on fourth falling edge after start bit
// [RULE19] word order is start, single-ended, polarity, bit order on rising edges
`include "saps_defines.vh"
`default_nettype none

module saps_fifo #(
   parameter WIDTH = 11,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys, // system clock
   input wire reset, // async reset, active high
   input wire [WIDTH-1:0] in_data, // word to store
   input wire in_valid, // store request
   output wire in_ready, // room for a word
   output wire [WIDTH-1:0] out_data, // oldest word
   output wire out_valid, // a word is waiting
   input wire out_ready, // drain request
   output wire [AW:0] count // words held
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] fill;
   wire do_push;
   wire do_pop;
   // full and empty come from the fill count, so depth need not be a power of two
   assign in_ready = (fill != DEPTH[AW:0]);
   assign out_valid = (fill != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign count = fill;
   assign do_push = in_valid & in_ready;
   assign do_pop = out_valid & out_ready;
   // pointer and fill bookkeeping
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill <= {(AW+1){1'b0}};
      end else begin
         if (do_push)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (do_push & ~do_pop)
            fill <= fill + 1'b1;
         else if (do_pop & ~do_push)
            fill <= fill - 1'b1;
      end
   end
   // storage needs no reset; out_valid guards stale words
   always @(posedge clk_sys) begin
      if (do_push)
         mem[wr_ptr] <= in_data;
   end
endmodule

module saps_top #(
   parameter ADDR_W = 8,
   parameter FIFO_DEPTH = `SAPS_FIFO_DEPTH,
   parameter FIFO_AW = 4
) (
   input wire clk_sys, // 40 MHz system clock
   input wire reset, // async reset, active high
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction, high for write
   input wire [ADDR_W-1:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb transfer done
   output reg pslverr, // apb error for unmapped address
   input wire select_powerdown_n, // select pin, low while active
   input wire shift_clk, // shift clock pin from host
   input wire serial_in_line, // serial data in pin
   input wire [7:0] input_zero, // sampled level of first input
   input wire [7:0] input_one, // sampled level of second input
   output reg serial_out_line, // serial data out level
   output reg serial_out_oe // serial data out drive enable
);
   localparam RW = `SAPS_RESULT_BITS;
   localparam CW = `SAPS_CFG_BITS;
   localparam EW = RW + CW;
   // one-hot link states
   localparam ST_IDLE = 7'h01;
   localparam ST_HUNT = 7'h02;
   localparam ST_CONFIG = 7'h04;
   localparam ST_NULL = 7'h08;
   localparam ST_CONVERT = 7'h10;
   localparam ST_TAIL = 7'h20;
   localparam ST_ZEROS = 7'h40;
   // pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges
   reg [2:0] sel_sync;
   reg [2:0] clk_sync;
   reg [1:0] din_sync;
   reg [6:0] state;
   reg [2:0] bit_cnt;
   reg [CW-1:0] cfg;
   reg [RW-1:0] sample;
   reg [RW-1:0] code;
   reg [1:0] ctrl;
   reg [EW-1:0] last_entry;
   reg [15:0] xfer_count;
   reg push_req;
   wire sel_low;
   wire sel_fall;
   wire sclk_rise;
   wire sclk_fall;
   wire din_bit;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [EW-1:0] fifo_out_data;
   wire [FIFO_AW:0] fifo_count;
   wire capture_on;
   wire may_start;
   wire apb_setup;
   wire apb_done;
   wire [RW-1:0] trial;
   wire trial_bit;
   reg [31:0] next_prdata;
   reg next_err;
   reg pop_now;
   // selected analog value, unsigned; a negative difference reads as zero
   function [7:0] pick_input;
      input [2:0] c;
      input [7:0] a;
      input [7:0] b;
      begin
         if (c[`SAPS_CFG_SGL_BIT])
            pick_input = c[`SAPS_CFG_POL_BIT] ? b : a; // [RULE14] [RULE16]
         else if (c[`SAPS_CFG_POL_BIT])
            pick_input = (b > a) ? b - a : 8'h00; // [RULE16]
         else
            pick_input = (a > b) ? a - b : 8'h00; // [RULE16]
      end
   endfunction
   assign sel_low = ~sel_sync[1];
   assign sel_fall = sel_sync[2] & ~sel_sync[1];
   assign sclk_rise = clk_sync[1] & ~clk_sync[2]; // [RULE2]
   assign sclk_fall = clk_sync[2] & ~clk_sync[1]; // [RULE2]
   assign din_bit = din_sync[1];
   assign capture_on = ctrl[`SAPS_CTRL_CAPTURE_BIT];
   // a full buffer holds off new transfers instead of losing results
   assign may_start = fifo_in_ready | ~capture_on;
   assign trial = code | (8'h01 << bit_cnt);
   assign trial_bit = (sample >= trial); // [RULE13]
   // two-flop synchronisers for every pin
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sel_sync <= 3'h7;
         clk_sync <= 3'h0;
         din_sync <= 2'h0;
      end else begin
         sel_sync <= {sel_sync[1:0], select_powerdown_n};
         clk_sync <= {clk_sync[1:0], shift_clk};
         din_sync <= {din_sync[0], serial_in_line};
      end
   end
   // link sequencer, stepped by synchronised shift clock edges
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         cfg <= `SAPS_CFG_RESET;
         sample <= 8'h00;
         code <= 8'h00;
         serial_out_line <= 1'b0;
         serial_out_oe <= 1'b0;
         push_req <= 1'b0;
         last_entry <= {EW{1'b0}};
         xfer_count <= 16'h0000;
      end else begin
         push_req <= 1'b0;
         if (!sel_low) begin
            state <= ST_IDLE; // [RULE1] [RULE7]
            serial_out_oe <= 1'b0; // [RULE1]
            serial_out_line <= 1'b0;
         end else if (sel_fall) begin
            state <= ST_HUNT; // [RULE4]
            bit_cnt <= 3'h0;
         end else begin
            case (state)
               ST_HUNT: begin
                  // multiplexed mode skips leading zeros and takes the first one as the start; fixed mode starts on the first rise
                  if (sclk_rise && may_start) begin
                     if (ctrl[`SAPS_CTRL_FIXED_BIT]) begin
                        cfg <= `SAPS_CFG_RESET; // [RULE8]
                        state <= ST_NULL; // [RULE8]
                     end else if (din_bit) begin
                        state <= ST_CONFIG; // [RULE15]
                        bit_cnt <= 3'h0;
                     end
                  end
               end
               ST_CONFIG: begin
                  if (sclk_rise) begin
                     cfg <= {cfg[CW-2:0], din_bit}; // [RULE5] [RULE19]
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h2)
                        state <= ST_NULL; // [RULE5]
                  end
               end
               ST_NULL: begin
                  // fourth falling edge after the start, or the first falling edge in fixed mode: take the wire, drive low
                  if (sclk_fall) begin
                     serial_out_oe <= 1'b1; // [RULE3] [RULE8] [RULE18]
                     serial_out_line <= 1'b0; // [RULE6]
                     sample <= pick_input(cfg, input_zero, input_one); // [RULE14]
                     code <= 8'h00;
                     bit_cnt <= `SAPS_MSB_INDEX;
                     state <= ST_CONVERT;
                  end
               end
               ST_CONVERT: begin
                  // one approximation step per bit, each decision sent at once
                  if (sclk_fall) begin
                     serial_out_line <= trial_bit; // [RULE6] [RULE13]
                     if (trial_bit)
                        code <= trial;
                     if (bit_cnt == 3'h0) begin
                        push_req <= capture_on;
                        last_entry <= {cfg, (trial_bit ? trial : code)};
                        xfer_count <= xfer_count + 16'h0001;
                        bit_cnt <= `SAPS_LSB_REPLAY_FIRST;
                        state <= cfg[`SAPS_CFG_BIT_ORDER_FLAG_BIT] ? ST_ZEROS : ST_TAIL; // [RULE17]
                     end else begin
                        bit_cnt <= bit_cnt - 3'h1;
                     end
                  end
               end
               ST_TAIL: begin
                  // lsb-first replay; bit 0 was the last msb-first bit
                  if (sclk_fall) begin
                     serial_out_line <= code[bit_cnt]; // [RULE17]
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == `SAPS_MSB_INDEX)
                        state <= ST_ZEROS;
                  end
               end
               ST_ZEROS: begin
                  // input is ignored here until the next select fall
                  if (sclk_fall)
                     serial_out_line <= 1'b0; // [RULE12] [RULE15]
               end
               default: begin
                  if (sclk_fall)
                     serial_out_line <= 1'b0;
               end
            endcase
         end
      end
   end
   saps_fifo #(
      .WIDTH(EW),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_data(last_entry),
      .in_valid(push_req),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(pop_now),
      .count(fifo_count)
   );
   assign apb_setup = psel & penable & ~pready;
   assign apb_done = psel & penable & pready;
   // read mux and decode, evaluated in the wait cycle of the access phase
   always @* begin
      next_prdata = 32'h00000000;
      next_err = 1'b0;
      pop_now = 1'b0;
      case (paddr)
         `SAPS_OFS_CTRL: begin
            next_prdata[1:0] = ctrl;
         end
         `SAPS_OFS_STATUS: begin
            next_prdata[`SAPS_STAT_ACTIVE_BIT] = sel_low;
            next_prdata[`SAPS_STAT_STATE_LSB +: 7] = state;
            next_prdata[`SAPS_STAT_COUNT_LSB +: 5] = fifo_count[4:0];
            next_prdata[`SAPS_STAT_FULL_BIT] = ~fifo_in_ready;
         end
         `SAPS_OFS_DATA: begin
            next_prdata[EW-1:0] = fifo_out_valid ? fifo_out_data : {EW{1'b0}};
            next_prdata[`SAPS_DATA_VALID_BIT] = fifo_out_valid;
            pop_now = apb_setup & ~pwrite; // read of data pops one entry
         end
         `SAPS_OFS_LAST: begin
            next_prdata[EW-1:0] = last_entry;
            next_prdata[`SAPS_LAST_COUNT_LSB +: 16] = xfer_count;
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end
   // apb slave: one wait state, so every answer comes from a flip-flop
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         ctrl <= `SAPS_CTRL_RESET;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & next_err;
         if (apb_setup && !pwrite)
            prdata <= next_prdata;
         if (apb_done && pwrite && paddr == `SAPS_OFS_CTRL)
            ctrl <= pwdata[1:0];
      end
   end
endmodule

`default_nettype wire

// ### verification/saps_top_chk.sv
`include "saps_defines.vh"
`default_nettype none
module saps_top_chk #(
   parameter ADDR_W = 8
) (
   input wire logic clk_sys, // system clock
   input wire logic reset, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic [ADDR_W-1:0] paddr, // apb address
   input wire logic pwrite, // apb direction
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb done
   input wire logic pslverr, // apb error
   input wire logic select_powerdown_n, // select pin
   input wire logic shift_clk, // shift clock pin
   input wire logic serial_out_line, // data out
   input wire logic serial_out_oe // data out enable
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // serial side: out moves only in the low phase, enable follows select
   idle_quiet_a: assert property (select_powerdown_n [*8] |-> !serial_out_oe)
      else $error("output enabled while deselected");
   sel_release_a: assert property ($rose(select_powerdown_n) |-> ##[1:8] !serial_out_oe)
      else $error("output not released after select rose");
   out_on_fall_a: assert property (serial_out_oe && $past(serial_out_oe) && !select_powerdown_n
      && $changed(serial_out_line) |-> !shift_clk) else $error("data out moved in high phase");
   null_first_a: assert property ($rose(serial_out_oe) |-> !serial_out_line && !shift_clk
      && !select_powerdown_n) else $error("enable not on a fall with null bit");
   oe_hold_a: assert property ($fell(serial_out_oe) |-> select_powerdown_n)
      else $error("output dropped while still selected");
   // apb side: fixed two-cycle access, error only for unmapped places
   ready_time_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_qual_a: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside a transfer");
   // read data only moves on reads, so a refused write keeps the old word
   unmapped_err_a: assert property (pready && paddr > `SAPS_OFS_LAST |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready && paddr <= `SAPS_OFS_LAST && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
endmodule
bind saps_top saps_top_chk #(.ADDR_W(ADDR_W)) u_saps_top_chk (.clk_sys(clk_sys), .reset(reset),
   .psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr),
   .select_powerdown_n(select_powerdown_n), .shift_clk(shift_clk), .serial_out_line(serial_out_line),
   .serial_out_oe(serial_out_oe));
`default_nettype wire

// ### verification/saps_host_model.sv
`default_nettype none
module saps_host_model #(
   parameter int HALF = 8, // clk_sys cycles per shift half period
   parameter int WAKE = 400 // 10 us at 40 MHz
) (
   input wire logic clk_sys, // system clock
   input wire logic serial_out_line, // device data out
   input wire logic serial_out_oe, // device drive enable
   output logic select_powerdown_n, // select, low while active
   output logic shift_clk, // shift clock, still between frames
   output logic din // resolved shared wire
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hoe = 1'b0;
   logic hbit = 1'b0;
   initial begin
      select_powerdown_n = 1'b1;
      shift_clk = 1'b0;
   end
   // an undriven wire shows the inverse of the last host bit, never a stale copy
   assign din = serial_out_oe ? serial_out_line : (hoe ? hbit : ~hbit);
   // one framed exchange; n shift clocks, bits sampled after the header
   task automatic run(input logic fixed, input logic [2:0] cfg, input int n, output logic [23:0] bits,
      output logic saw);
      int hdr;
      logic [4:0] hb;
      hdr = fixed ? 1 : 5;
      hb = {2'h1, cfg}; // leading zero, start, sgl, pol, bit_order_flag
      bits = 24'h0;
      saw = 1'b0;
      @(posedge clk_sys);
      select_powerdown_n <= 1'b0;
      hoe <= !fixed;
      // fast shift clock, so the wake-up wait is explicit
      repeat (WAKE) @(posedge clk_sys);
      for (int k = 0; k < n; k++) begin
         if (!fixed && k < 5) hbit <= hb[4 - k];
         repeat (HALF) @(posedge clk_sys);
         shift_clk <= 1'b1;
         if (k >= hdr && k - hdr < 24) bits[k - hdr] = din;
         saw = saw | (serial_out_oe === 1'b1);
         repeat (HALF / 2) @(posedge clk_sys);
         if (k == 4) hoe <= 1'b0;
         repeat (HALF / 2) @(posedge clk_sys);
         shift_clk <= 1'b0;
      end
      repeat (HALF) @(posedge clk_sys);
      select_powerdown_n <= 1'b1;
      hoe <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ### verification/saps_top_bench.sv
`include "saps_defines.vh"
`default_nettype none
module saps_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0, iz = 8'h5a, io = 8'h3c;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, soe, sout, sel_n, sclk, din, err, saw;
   logic [23:0] bits;
   logic [2:0] cfgs [4] = '{3'h5, 3'h6, 3'h1, 3'h2};
   int bad_count = 0, total_checks = 0;
   saps_top u_saps_top (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .select_powerdown_n(sel_n), .shift_clk(sclk), .serial_in_line(din), .input_zero(iz),
      .input_one(io), .serial_out_line(sout), .serial_out_oe(soe));
   saps_host_model u_saps_host_model (.clk_sys(clk_sys), .serial_out_line(sout), .serial_out_oe(soe),
      .select_powerdown_n(sel_n), .shift_clk(sclk), .din(din));
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t reg got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bits(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t stream got %h exp %h", $time, g, e);
      end
   endtask
   // apb master; waits for pready under a bound, a hang ends the run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         $display("CHECK FAILED t=%0t no pready", $time);
         conclude();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ideal converter: sample >= trial gives the input itself, negative clips to zero
   function automatic logic [7:0] conv(input logic [2:0] c);
      if (c[2]) return c[1] ? io : iz;
      if (c[1]) return io > iz ? io - iz : 8'h0;
      return iz > io ? iz - io : 8'h0;
   endfunction
   function automatic logic [23:0] stream(input logic [7:0] r, input logic lsb);
      logic [23:0] s;
      s = 24'h0;
      for (int i = 0; i < 8; i++) s[1 + i] = r[7 - i];
      for (int i = 0; i < 7; i++) s[9 + i] = lsb & r[1 + i];
      return s;
   endfunction
   task automatic xfer(input logic fx, input logic [2:0] c, input logic [7:0] r, input logic lsb);
      u_saps_host_model.run(fx, c, fx ? 25 : 29, bits, saw);
      chk_bits(bits, stream(r, lsb));
      apb(1'b0, `SAPS_OFS_DATA, 32'h0);
      chk_reg(q & 32'h107ff, {15'h0, 1'b1, 5'h0, c, r});
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      apb(1'b0, `SAPS_OFS_CTRL, 32'h0);
      chk_reg(q, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      chk_reg({q[30:0], err}, 32'h1);
      // every mux code and both orders on the shared wire
      for (int i = 0; i < 4; i++) xfer(1'b0, cfgs[i], conv(cfgs[i]), !cfgs[i][0]);
      apb(1'b1, `SAPS_OFS_CTRL, 32'h3);
      xfer(1'b1, 3'h5, iz, 1'b0);
      // abort in mid-result leaves nothing behind
      u_saps_host_model.run(1'b1, 3'h5, 6, bits, saw);
      apb(1'b0, `SAPS_OFS_DATA, 32'h0);
      chk_reg({31'h0, q[`SAPS_DATA_VALID_BIT]}, 32'h0);
      // fill the buffer, then a further start must be refused
      for (int i = 0; i < 16; i++) u_saps_host_model.run(1'b1, 3'h5, 25, bits, saw);
      apb(1'b0, `SAPS_OFS_STATUS, 32'h0);
      chk_reg({26'h0, q[13:8]}, 32'h30);
      u_saps_host_model.run(1'b1, 3'h5, 25, bits, saw);
      chk_reg({31'h0, saw}, 32'h0);
      for (int i = 0; i < 16; i++) begin
         apb(1'b0, `SAPS_OFS_DATA, 32'h0);
         chk_reg(q & 32'h107ff, {15'h0, 1'b1, 5'h0, 3'h5, iz});
      end
      apb(1'b0, `SAPS_OFS_DATA, 32'h0);
      chk_reg({31'h0, q[`SAPS_DATA_VALID_BIT]}, 32'h0);
      apb(1'b0, `SAPS_OFS_LAST, 32'h0);
      chk_reg({21'h0, q[10:0]}, {21'h0, 3'h5, iz});
      // capture off: the transfer still runs and counts, but nothing is queued
      apb(1'b1, `SAPS_OFS_CTRL, 32'h1);
      u_saps_host_model.run(1'b1, 3'h5, 25, bits, saw);
      chk_bits(bits, stream(iz, 1'b0));
      apb(1'b0, `SAPS_OFS_DATA, 32'h0);
      chk_reg({31'h0, q[`SAPS_DATA_VALID_BIT]}, 32'h0);
      apb(1'b0, `SAPS_OFS_LAST, 32'h0);
      chk_reg(q & 32'hffff07ff, {16'h0016, 5'h0, 3'h5, iz});
      conclude();
   end
endmodule
`default_nettype wire
